// file: hw/hnp_defs.svh
`ifndef HNP_DEFS_SVH
`define HNP_DEFS_SVH

`define HNP_OFS_AUX 8'h52
`define HNP_OFS_TRIG 8'h53
`define HNP_OFS_PCC 8'h54
`define HNP_OFS_STAT 8'h55
`define HNP_RST_AUX 8'h00
`define HNP_RST_TRIG 8'h3E
`define HNP_RST_PCC 8'h01
`define HNP_MASK_AUX 8'h07
`define HNP_MASK_TRIG 8'h3F
`define HNP_MASK_PCC 8'h07
`define HNP_BIT_POL 5
`define HNP_BIT_LEN 4
`define HNP_BIT_FW 3
`define HNP_BIT_ST 2
`define HNP_BIT_AQE 1
`define HNP_BIT_AQD 0
`define HNP_BIT_SLOPE 2
`define HNP_BIT_REL 1
`define HNP_BIT_FIX 0
`define HNP_AUX_SW_LOW 3'h4
`define HNP_AUX_SW_HIGH 3'h5
`define HNP_CLK_HZ 200000000
`define HNP_TICK_HZ 1000
`define HNP_TICK_DIV (`HNP_CLK_HZ / `HNP_TICK_HZ)
`define HNP_TICK_RESTART 1
`define HNP_LEN_SHORT_MS 4
`define HNP_LEN_LONG_MS 8

`endif

// file: hw/hnp_pkg.sv
package hnp_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hnp_bus_t;

    typedef struct packed {
        logic fw_fail;
        logic selftest_fail;
        logic acq_fail;
        logic acq_done;
        logic slope_hit;
        logic rel_hit;
        logic fix_hit;
    } hnp_evt_t;

    typedef enum logic [0:0] {
        HNP_IDLE,
        HNP_PULSE
    } hnp_state_t;

endpackage

// file: hw/hnp_tick.sv
`include "hnp_defs.svh"

module hnp_tick (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    output logic tick
);

    typedef struct packed {
        logic [17:0] cnt;
        logic tick;
    } hnp_tick_st_t;

    hnp_tick_st_t st_r;
    hnp_tick_st_t st_nxt;

    // One-millisecond enable stands in for the low-frequency clock.
    // Restarting at one puts the first tick a whole millisecond of edges after the pulse began.
    always_comb begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (restart) begin
            st_nxt.cnt = 18'(`HNP_TICK_RESTART);
        end else if (st_r.cnt == 18'(`HNP_TICK_DIV - 1)) begin
            st_nxt.cnt = 18'h0;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.cnt = st_r.cnt + 18'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule

// file: hw/hnp_notify.sv
`include "hnp_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Auxiliary function codes 000 to 011 leave the auxiliary pin disabled.
// - Code 100 drives supply switch enable, idle high, asserted low.
// - Code 101 drives supply switch enable, idle low, asserted high.
// - All other auxiliary codes, including 111, leave the pin disabled.
// - Trigger bit 5 picks notify pin polarity; 0 idles high, pulses low.
// - Trigger bit 4 picks pulse length: 4 ms clear, 8 ms set.
// - Trigger bit 3 enables a pulse on firmware check failure.
// - Trigger bit 2 enables a pulse on self-test failure.
// - Trigger bit 1 enables a pulse on acquisition failure.
// - Trigger bit 0 enables a pulse on each acquisition completed while no pulse is running.
// - Pressure-change bit 2 enables slope threshold watching.
// - Pressure-change bit 1 enables relative threshold watching.
// - Pressure-change bit 0 enables fixed threshold watching.
// - A met enabled threshold sets the notify flag and pulses the pin.
// - Flags clear at end of serial transfers only after an acknowledge.
module hnp_notify (
    input wire logic clk,
    input wire logic rst_n,
    input wire hnp_pkg::hnp_bus_t bus,
    output logic [7:0] rdata,
    input wire hnp_pkg::hnp_evt_t evt,
    input wire logic notify_ack_command,
    input wire logic xfer_done,
    output logic notify_pin,
    output logic aux_port_pin,
    output logic aux_port_pin_oe_n,
    input wire logic supply_switch_enable,
    output logic slope_watch_enable,
    output logic relative_watch_enable,
    output logic fixed_watch_enable,
    output logic notify_flag
);

    typedef struct packed {
        logic [7:0] aux_pin_function;
        logic [7:0] notify_trigger_config;
        logic [7:0] pressure_change_config;
        logic [6:0] evt_flags;
        logic notify_flag;
        logic ack_seen;
        hnp_pkg::hnp_state_t state;
        logic [3:0] ms_left;
        logic [7:0] rdata;
        logic notify_pin;
        logic aux_pin;
        logic aux_oe_n;
    } hnp_st_t;

    hnp_st_t st_r;
    hnp_st_t st_nxt;
    logic tick;
    logic fire;
    logic [6:0] evt_vec;
    logic tick_restart;

    hnp_tick u_tick (
        .clk(clk),
        .rst_n(rst_n),
        .restart(tick_restart),
        .tick(tick)
    );

    function automatic logic idle_level(input logic [7:0] trig);
        idle_level = ~trig[`HNP_BIT_POL];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [3:0] pulse_ms(input logic [7:0] trig);
        if (trig[`HNP_BIT_LEN]) begin
            pulse_ms = 4'(`HNP_LEN_LONG_MS);
        end else begin
            pulse_ms = 4'(`HNP_LEN_SHORT_MS);
        end
    endfunction

    // Reserved bits and unmapped offsets read back as zero.
    function automatic logic [7:0] reg_read(input hnp_st_t st, input logic [7:0] addr);
        case (addr)
            `HNP_OFS_AUX: reg_read = st.aux_pin_function;
            `HNP_OFS_TRIG: reg_read = st.notify_trigger_config;
            `HNP_OFS_PCC: reg_read = st.pressure_change_config;
            `HNP_OFS_STAT: reg_read = {st.notify_flag, st.evt_flags};
            default: reg_read = 8'h00;
        endcase
    endfunction

    // Returns the active-low output enable and the pin level for an auxiliary function code.
    function automatic logic [1:0] aux_drive(input logic [2:0] code, input logic req);
        case (code)
            `HNP_AUX_SW_LOW: begin
                aux_drive = {1'b0, ~req};
            end
            `HNP_AUX_SW_HIGH: begin
                aux_drive = {1'b0, req};
            end
            default: begin
                aux_drive = 2'h2;
            end
        endcase
    endfunction

    function automatic logic watch_hit(input logic [7:0] pcc, input hnp_pkg::hnp_evt_t ev);
        watch_hit = (pcc[`HNP_BIT_SLOPE] && ev.slope_hit) ||
            (pcc[`HNP_BIT_REL] && ev.rel_hit) ||
            (pcc[`HNP_BIT_FIX] && ev.fix_hit);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign evt_vec = evt;
    // The divider restarts with each pulse so that no counted millisecond is partial.
    assign tick_restart = fire && (st_r.state == hnp_pkg::HNP_IDLE);

    always_comb begin
        fire = 1'b0;
        if (st_r.notify_trigger_config[`HNP_BIT_FW] && evt.fw_fail) begin
            fire = 1'b1;
        end
        if (st_r.notify_trigger_config[`HNP_BIT_ST] && evt.selftest_fail) begin
            fire = 1'b1;
        end
        if (st_r.notify_trigger_config[`HNP_BIT_AQE] && evt.acq_fail) begin
            fire = 1'b1;
        end
        if (st_r.notify_trigger_config[`HNP_BIT_AQD] && evt.acq_done) begin
            fire = 1'b1;
        end
        if (watch_hit(st_r.pressure_change_config, evt)) begin
            fire = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_nxt = st_r;
        // Register writes; reserved bits are masked and read as zero.
        if (bus.wr) begin
            case (bus.addr)
                `HNP_OFS_AUX: begin
                    st_nxt.aux_pin_function = bus.wdata & `HNP_MASK_AUX;
                end
                `HNP_OFS_TRIG: begin
                    st_nxt.notify_trigger_config = bus.wdata & `HNP_MASK_TRIG;
                end
                `HNP_OFS_PCC: begin
                    st_nxt.pressure_change_config = bus.wdata & `HNP_MASK_PCC;
                end
                default: begin
                end
            endcase
        end
        if (bus.rd) begin
            st_nxt.rdata = reg_read(st_r, bus.addr);
        end
        // Acknowledge is remembered until the transfers close.
        if (notify_ack_command) begin
            st_nxt.ack_seen = 1'b1;
        end
        if (xfer_done && (st_r.ack_seen || notify_ack_command)) begin
            st_nxt.evt_flags = 7'h00;
            st_nxt.notify_flag = 1'b0;
            st_nxt.ack_seen = 1'b0;
        end
        // A new event wins over a clear in the same cycle.
        st_nxt.evt_flags = st_nxt.evt_flags | evt_vec;
        if (fire) begin
            st_nxt.notify_flag = 1'b1;
        end
        case (st_r.state)
            hnp_pkg::HNP_IDLE: begin
                if (fire) begin
                    st_nxt.state = hnp_pkg::HNP_PULSE;
                    st_nxt.ms_left = pulse_ms(st_r.notify_trigger_config);
                end
            end
            hnp_pkg::HNP_PULSE: begin
                // Further events are ignored here so a pulse never stretches.
                if (tick) begin
                    st_nxt.ms_left = st_r.ms_left - 4'h1;
                    if (st_r.ms_left == 4'h1) begin
                        st_nxt.state = hnp_pkg::HNP_IDLE;
                    end
                end
            end
            default: st_nxt.state = hnp_pkg::HNP_IDLE;
        endcase
        // Driving the pin from the next state keeps it on the same edge as the state change.
        if (st_nxt.state == hnp_pkg::HNP_PULSE) begin
            st_nxt.notify_pin = ~idle_level(st_nxt.notify_trigger_config);
        end else begin
            st_nxt.notify_pin = idle_level(st_nxt.notify_trigger_config);
        end
        {st_nxt.aux_oe_n, st_nxt.aux_pin} = aux_drive(st_nxt.aux_pin_function[2:0], supply_switch_enable);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.aux_pin_function <= `HNP_RST_AUX;
            st_r.notify_trigger_config <= `HNP_RST_TRIG;
            st_r.pressure_change_config <= `HNP_RST_PCC;
            st_r.state <= hnp_pkg::HNP_IDLE;
            st_r.notify_pin <= 1'b0;
            st_r.aux_oe_n <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign rdata = st_r.rdata;
    assign notify_pin = st_r.notify_pin;
    assign aux_port_pin = st_r.aux_pin;
    assign aux_port_pin_oe_n = st_r.aux_oe_n;
    assign slope_watch_enable = st_r.pressure_change_config[`HNP_BIT_SLOPE];
    assign relative_watch_enable = st_r.pressure_change_config[`HNP_BIT_REL];
    assign fixed_watch_enable = st_r.pressure_change_config[`HNP_BIT_FIX];
    assign notify_flag = st_r.notify_flag;

endmodule

// file: verification/hnp_host_model.sv
////////////////////////////////////////////////////////////////////////////////
// Host side: register strobes, acknowledge and end of transfers, all at falling edges.
module hnp_host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output hnp_pkg::hnp_bus_t bus,
    output logic notify_ack_command,
    output logic xfer_done
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        bus = '0;
        notify_ack_command = 1'b0;
        xfer_done = 1'b0;
    end
    // Released address and data are inverted so stale values never look valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        bus = {2'b10, a, d & ((a == 8'h53) ? 8'h3F : 8'h07)};
        @(negedge clk);
        bus = {2'b00, ~a, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        bus = {2'b01, a, 8'h00};
        @(negedge clk);
        bus = {2'b00, ~a, 8'hFF};
        d = rdata;
    endtask
    task automatic ack;
        @(negedge clk);
        notify_ack_command = 1'b1;
        @(negedge clk);
        notify_ack_command = 1'b0;
        xfer_done = 1'b1;
        @(negedge clk);
        xfer_done = 1'b0;
    endtask
endmodule

// file: verification/hnp_notify_properties.sv
module hnp_notify_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire hnp_pkg::hnp_bus_t bus,
    input wire hnp_pkg::hnp_evt_t evt,
    input wire logic notify_ack_command,
    input wire logic xfer_done,
    input wire logic notify_pin,
    input wire logic aux_port_pin,
    input wire logic aux_port_pin_oe_n,
    input wire logic supply_switch_enable,
    input wire logic slope_watch_enable,
    input wire logic relative_watch_enable,
    input wire logic fixed_watch_enable,
    input wire logic notify_flag
);
    logic [7:0] trig_r;
    logic [2:0] aux_r;
    logic act;
    assign act = notify_pin == trig_r[5];
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            trig_r <= 8'h3E;
            aux_r <= 3'h0;
        end else if (bus.wr && bus.addr == 8'h53) begin
            trig_r <= bus.wdata;
        end else if (bus.wr && bus.addr == 8'h52) begin
            aux_r <= bus.wdata[2:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_ack;
        notify_ack_command ##1 (xfer_done && evt == '0);
    endsequence
    property p_fires(ev, en);
        ev && en && !act |=> act && notify_flag;
    endproperty
    a_aux_pin_off: assert property (aux_r[2:1] != 2'b10 |-> aux_port_pin_oe_n)
        else $error("aux pin driven");
    a_switch_low: assert property (aux_r == 3'h4 |-> !aux_port_pin_oe_n && aux_port_pin == !$past(supply_switch_enable))
        else $error("switch low bad");
    a_switch_high: assert property (aux_r == 3'h5 |-> !aux_port_pin_oe_n && aux_port_pin == $past(supply_switch_enable))
        else $error("switch high bad");
    a_fw_pulse: assert property (p_fires(evt.fw_fail, trig_r[3]))
        else $error("fw pulse missing");
    a_st_pulse: assert property (p_fires(evt.selftest_fail, trig_r[2]))
        else $error("selftest pulse missing");
    a_aqe_pulse: assert property (p_fires(evt.acq_fail, trig_r[1]))
        else $error("acq fail pulse missing");
    a_aqd_pulse: assert property (p_fires(evt.acq_done, trig_r[0]))
        else $error("acq done pulse missing");
    a_fix_pulse: assert property (p_fires(evt.fix_hit, fixed_watch_enable))
        else $error("threshold pulse missing");
    a_rel_pulse: assert property (p_fires(evt.rel_hit, relative_watch_enable))
        else $error("relative pulse missing");
    a_slope_pulse: assert property (p_fires(evt.slope_hit, slope_watch_enable))
        else $error("slope pulse missing");
    // A polarity change moves the idle level, so that edge is not a pulse start.
    a_pulse_holds: assert property ($rose(act) && $stable(trig_r[5]) |=> act [*8])
        else $error("pulse cut short");
    a_watch_follow: assert property (bus.wr && bus.addr == 8'h54 |=>
        {slope_watch_enable, relative_watch_enable, fixed_watch_enable} == $past(bus.wdata[2:0]))
        else $error("watch enables wrong");
    a_ack_clears: assert property (s_ack |=> !notify_flag)
        else $error("flag not cleared");
endmodule
bind hnp_notify hnp_notify_checker u_chk (.clk(clk), .rst_n(rst_n), .bus(bus), .evt(evt),
    .notify_ack_command(notify_ack_command), .xfer_done(xfer_done), .notify_pin(notify_pin),
    .aux_port_pin(aux_port_pin), .aux_port_pin_oe_n(aux_port_pin_oe_n), .supply_switch_enable(supply_switch_enable),
    .slope_watch_enable(slope_watch_enable), .relative_watch_enable(relative_watch_enable),
    .fixed_watch_enable(fixed_watch_enable), .notify_flag(notify_flag));

// file: verification/hnp_notify_tb_top.sv
module hnp_notify_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sse = 1'b0;
    hnp_pkg::hnp_evt_t evt = '0;
    hnp_pkg::hnp_evt_t ev;
    hnp_pkg::hnp_bus_t bus;
    logic [7:0] rdata;
    logic [7:0] d;
    logic ack, xdone, pin, apin, aoe_n, sw, rw, fw, flag;
    int fail_count = 0;
    int samples_checked = 0;
    always #2.5 clk = ~clk;
    hnp_host_model host (.clk(clk), .rdata(rdata), .bus(bus), .notify_ack_command(ack), .xfer_done(xdone));
    hnp_notify dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .evt(evt), .notify_ack_command(ack),
        .xfer_done(xdone), .notify_pin(pin), .aux_port_pin(apin), .aux_port_pin_oe_n(aoe_n),
        .supply_switch_enable(sse), .slope_watch_enable(sw), .relative_watch_enable(rw),
        .fixed_watch_enable(fw), .notify_flag(flag));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Reset is the only way to end a pulse inside a short run.
    task automatic do_reset;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        host.rd(a, d);
        check(d, exp);
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        fail_count++;
        report_and_stop();
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        do_reset();
        rd_chk(8'h52, 8'h00);
        rd_chk(8'h53, 8'h3E);
        rd_chk(8'h54, 8'h01);
        rd_chk(8'h60, 8'h00);
        check({5'h00, sw, rw, fw}, 8'h01);
        host.wr(8'h54, 8'h06);
        @(negedge clk);
        check({5'h00, sw, rw, fw}, 8'h06);
        for (int c = 0; c < 8; c++) begin
            host.wr(8'h52, 8'(c));
            for (int s = 0; s < 2; s++) begin
                sse = s[0];
                repeat (2) @(negedge clk);
                check({7'h00, aoe_n}, {7'h00, !(c inside {4, 5})});
                if (c inside {4, 5}) check({7'h00, apin}, {7'h00, s[0] ^ (c == 4)});
            end
        end
        for (int k = 0; k < 7; k++) begin
            for (int en = 0; en < 2; en++) begin
                do_reset();
                ev = hnp_pkg::hnp_evt_t'((k < 4) ? 7'h08 << k : 7'h01 << (k - 4));
                host.wr(8'h53, {2'b00, k[0], k[1], (en == 1 && k < 4) ? 4'(1 << k) : 4'h0});
                host.wr(8'h54, (en == 1 && k >= 4) ? 8'(1 << (k - 4)) : 8'h00);
                evt = ev;
                @(negedge clk);
                evt = '0;
                check({6'h00, pin, flag}, {6'h00, k[0] ~^ en[0], en[0]});
                rd_chk(8'h55, {en[0], ev});
                evt = ev;
                repeat (20) @(negedge clk);
                evt = '0;
                check({7'h00, pin}, {7'h00, k[0] ~^ en[0]});
                host.ack();
                rd_chk(8'h55, 8'h00);
            end
        end
        report_and_stop();
    end
endmodule
